// file: verilog/nvmpi_consts.svh
// Purpose: Constants of the memory programming front end
// Assumes: 200 MHz system clock
// Notes: Times in microseconds, counts derived in the core
`ifndef NVMPI_CONSTS_SVH
`define NVMPI_CONSTS_SVH
`define NVMPI_CLK_PERIOD_NS 5
`define NVMPI_T_WD_FLASH_US 4500
`define NVMPI_T_WD_EEPROM_US 4000
`define NVMPI_T_WD_ERASE_US 9000
`define NVMPI_T_WD_FUSE_US 4500
`define NVMPI_ERASED 8'hFF
`define NVMPI_OPC_LD_LO 8'h40
`define NVMPI_OPC_LD_HI 8'h48
`define NVMPI_OPC_EE_LD 8'hC1
`define NVMPI_OPC_RD_HI 8'h28
`define NVMPI_OPC_RD_LO 8'h20
`define NVMPI_OPC_RD_EE 8'hA0
`define NVMPI_OPC_RD_LOCK 8'h58
`define NVMPI_OPC_RD_FUSE 8'h50
`define NVMPI_OPC_RD_SIG 8'h30
`define NVMPI_OPC_RD_CAL 8'h38
`define NVMPI_OPC_WR_PAGE 8'h4C
`define NVMPI_OPC_WR_EE 8'hC0
`define NVMPI_OPC_WR_EE_PG 8'hC2
`define NVMPI_OPC_AC 8'hAC
`define NVMPI_OPC_POLL 8'hF0
`define NVMPI_SUB_ENABLE 8'h53
`define NVMPI_SUB_ERASE 8'h80
`define NVMPI_SUB_LOCK 8'hE0
`define NVMPI_SUB_FUSE_LO 8'hA0
`define NVMPI_SUB_FUSE_HI 8'hA8
`define NVMPI_SUB_FUSE_EXT 8'hA4
`define NVMPI_SUB_HI_SEL 8'h08
`define NVMPI_CMD_ERASE 8'h80
`define NVMPI_CMD_WR_FUSE 8'h40
`define NVMPI_CMD_WR_LOCK 8'h20
`define NVMPI_CMD_WR_FLASH 8'h10
`define NVMPI_CMD_WR_EE 8'h11
`define NVMPI_CMD_RD_SIG 8'h08
`define NVMPI_CMD_RD_FUSE 8'h04
`define NVMPI_CMD_RD_FLASH 8'h02
`define NVMPI_CMD_RD_EE 8'h03
`define NVMPI_ACT_ADDR 2'h0
`define NVMPI_ACT_DATA 2'h1
`define NVMPI_ACT_CMD 2'h2
`endif

// file: verilog/nvmpi_pkg.sv
// Purpose: Types of the memory programming front end
// Assumes: Constants live in nvmpi_consts.svh
// Notes: One request format shared by serial and parallel paths
package nvmpi_pkg;
  typedef enum logic [3:0] {
    NVMPI_OP_NONE, NVMPI_OP_ERASE, NVMPI_OP_FLASH_LD_LO,
    NVMPI_OP_FLASH_LD_HI, NVMPI_OP_FLASH_WR, NVMPI_OP_EE_LD,
    NVMPI_OP_EE_WR_PAGE, NVMPI_OP_EE_WR_BYTE, NVMPI_OP_FUSE_LO,
    NVMPI_OP_FUSE_HI, NVMPI_OP_FUSE_EXT, NVMPI_OP_LOCK
  } nvmpi_op_type;

  typedef struct packed {
    nvmpi_op_type op;
    logic [15:0] addr;
    logic [7:0] data;
  } nvmpi_req_type;

  typedef struct packed {
    logic xtal;
    logic act_lo;
    logic act_hi;
    logic bsel;
    logic wr_n;
    logic oe_n;
    logic rst_pin_n;
    logic hv;
  } nvmpi_pins_type;

  typedef enum logic {NVMPI_IDLE, NVMPI_BUSY} nvmpi_state_type;
endpackage

// file: verilog/nvmpi_core.sv
// Purpose: Serial and parallel programming front end for flash, EEPROM,
//   fuses and lock bits
// Assumes: sck is the link clock; parallel pins are asynchronous
// Notes: Memories are plain arrays standing in for the cell arrays
`timescale 1ns/1ps
`include "nvmpi_consts.svh"

// How it works
// RQ1: Serial 0x40, address high, address low, data loads flash low byte.
// RQ2: Serial 0xC1, 0x00, byte index, data loads EEPROM page buffer.
// RQ3: Serial 0x28/0x20 with address return flash high/low byte fourth.
// RQ4: Serial 0x4C with address commits flash page buffer to that page.
// RQ5: Serial 0xC2 writes EEPROM page; only loaded bytes change.
// RQ6: Serial lock, fuse, calibration, signature reads answer in fourth byte.
// RQ7: Serial 0xAC with E0/A0/A8/A4 programs lock or fuse bytes.
// RQ8: Poll answer bit 0 is one while programming is pending.
// RQ9: Programmer loads low data byte before high byte per word.
// RQ10: Flash addresses are word addresses; page words load in any order.
// RQ11: Fuse and lock bits: zero programmed, one unprogrammed.
// RQ12: Programmer holds every parallel strobe at least 250 ns.
// RQ13: Data bus driven only while output enable low; write on low pulse.
// RQ14: Ready/busy low while programming, high when ready.
// RQ15: Byte selects pick low/high/extended; page latch pulse latches EEPROM.
// RQ16: Parallel entry needs page latch, actions and write strobe at zero.
// RQ17: Each rising load strobe pin performs the selected load action.
// RQ18: Action 00 address, 01 data, 10 command, 11 nothing.
// RQ19: Write or output-enable pulse runs last loaded command.
// RQ20: Write commands 80 erase, 40 fuses, 20 lock, 10 flash, 11 EEPROM.
// RQ21: Read commands 08 signature, 04 fuse/lock, 02 flash, 03 EEPROM.
// RQ22: Single-byte serial EEPROM read and write at given address.
// RQ23: Serial programming works only while reset pin is low.
// RQ24: Serial input sampled on rising, output shifted on falling sck.
// RQ25: Second enable byte 0x53 echoes while third byte shifts in.
module nvmpi_core #(
  parameter int FLASH_AW = 12,
  parameter int FLASH_PW = 5,
  parameter int EE_AW = 9,
  parameter int EE_PW = 2,
  parameter int T_FLASH_CYC =
    `NVMPI_T_WD_FLASH_US * 1000 / `NVMPI_CLK_PERIOD_NS,
  parameter int T_EEPROM_CYC =
    `NVMPI_T_WD_EEPROM_US * 1000 / `NVMPI_CLK_PERIOD_NS,
  parameter int T_ERASE_CYC =
    `NVMPI_T_WD_ERASE_US * 1000 / `NVMPI_CLK_PERIOD_NS,
  parameter int T_FUSE_CYC =
    `NVMPI_T_WD_FUSE_US * 1000 / `NVMPI_CLK_PERIOD_NS,
  // Identity values are arbitrary
  parameter logic [7:0] SIG_BYTE0 = 8'h5A,
  parameter logic [7:0] SIG_BYTE1 = 8'hA5,
  parameter logic [7:0] SIG_BYTE2 = 8'h3C,
  parameter logic [7:0] CAL_BYTE = 8'h80
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  input wire logic reset_pin_n,
  input wire logic hv_prog,
  input wire logic load_strobe_clock_pin,
  input wire logic action_select_lo,
  input wire logic action_select_hi,
  input wire logic byte_select_first,
  input wire logic write_n,
  input wire logic out_en_n,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_n,
  output logic ready_busy,
  output logic prog_active
);
  localparam int FLASH_WORDS = 2 ** FLASH_AW;
  localparam int FLASH_PAGE = 2 ** FLASH_PW;
  localparam int EE_BYTES = 2 ** EE_AW;
  localparam int EE_PAGE = 2 ** EE_PW;

  if (FLASH_PW >= FLASH_AW || EE_PW >= EE_AW || FLASH_AW > 16 ||
      EE_AW > 16 || T_ERASE_CYC >= 2 ** 24 || T_FLASH_CYC < 1 ||
      T_EEPROM_CYC < 1 || T_FUSE_CYC < 1) begin : g_bad_cfg
    $error("nvmpi_core: unsupported parameters");
  end

  logic [7:0] flash_lo [FLASH_WORDS];
  logic [7:0] flash_hi [FLASH_WORDS];
  logic [7:0] fbuf_lo [FLASH_PAGE];
  logic [7:0] fbuf_hi [FLASH_PAGE];
  logic [7:0] ee_mem [EE_BYTES];
  logic [7:0] ee_buf [EE_PAGE];
  logic [EE_PAGE-1:0] ee_mask_reg;
  logic [7:0] fuse_lo_reg, fuse_hi_reg, fuse_ext_reg, lock_reg;

  nvmpi_pkg::nvmpi_pins_type pins_raw, pin_s1, pin_s2, pin_s3;
  logic [7:0] din_s1, din_s2;
  logic par_mode_reg, ser_act_reg, prog_en_reg;
  nvmpi_pkg::nvmpi_state_type state_reg;
  logic [23:0] busy_cnt_reg;
  logic busy;
  nvmpi_pkg::nvmpi_req_type ser_req, par_req, req;

  function automatic logic is_prog(nvmpi_pkg::nvmpi_op_type op);
    case (op)
      nvmpi_pkg::NVMPI_OP_NONE, nvmpi_pkg::NVMPI_OP_FLASH_LD_LO,
      nvmpi_pkg::NVMPI_OP_FLASH_LD_HI, nvmpi_pkg::NVMPI_OP_EE_LD:
        is_prog = 1'b0;
      default: is_prog = 1'b1;
    endcase
  endfunction

  function automatic logic [23:0] op_cycles(nvmpi_pkg::nvmpi_op_type op);
    case (op)
      nvmpi_pkg::NVMPI_OP_ERASE: op_cycles = 24'(T_ERASE_CYC);
      nvmpi_pkg::NVMPI_OP_FLASH_WR: op_cycles = 24'(T_FLASH_CYC);
      nvmpi_pkg::NVMPI_OP_EE_WR_PAGE,
      nvmpi_pkg::NVMPI_OP_EE_WR_BYTE: op_cycles = 24'(T_EEPROM_CYC);
      default: op_cycles = 24'(T_FUSE_CYC);
    endcase
  endfunction

  function automatic logic [7:0] sig_byte(logic [1:0] idx);
    case (idx)
      2'h0: sig_byte = SIG_BYTE0;
      2'h1: sig_byte = SIG_BYTE1;
      2'h2: sig_byte = SIG_BYTE2;
      default: sig_byte = `NVMPI_ERASED;
    endcase
  endfunction

  // Pins are asynchronous; two flops before any logic
  assign pins_raw = '{xtal: load_strobe_clock_pin, act_lo: action_select_lo,
                      act_hi: action_select_hi, bsel: byte_select_first,
                      wr_n: write_n, oe_n: out_en_n,
                      rst_pin_n: reset_pin_n, hv: hv_prog};
  always_ff @(posedge clk) begin
    pin_s1 <= pins_raw;
    pin_s2 <= pin_s1;
    pin_s3 <= pin_s2;
    din_s1 <= data_in;
    din_s2 <= din_s1;
  end

  // Serial link, sck domain
  logic [1:0] off_s_reg;
  logic [6:0] rx_sh_reg;
  logic [2:0] bit_cnt_reg;
  logic [1:0] byte_idx_reg, rx_idx_reg;
  logic [7:0] rx_byte_reg, tx_sh_reg, ans_reg;
  logic rx_tgl_reg;

  always_ff @(posedge sck) begin
    off_s_reg <= {off_s_reg[0], ~ser_act_reg};
  end

  always_ff @(posedge sck) begin
    if (off_s_reg[1]) begin
      bit_cnt_reg <= 3'h0;
      byte_idx_reg <= 2'h0;
      rx_sh_reg <= 7'h00;
    end else begin
      rx_sh_reg <= {rx_sh_reg[5:0], mosi}; // see RQ24
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      if (bit_cnt_reg == 3'h7) begin
        byte_idx_reg <= byte_idx_reg + 2'h1;
      end
    end
  end

  // Byte and index hold still for a whole byte time after the toggle
  always_ff @(posedge sck) begin
    if (off_s_reg[1]) begin
      rx_tgl_reg <= 1'b0;
      rx_idx_reg <= 2'h0;
      rx_byte_reg <= 8'h00;
    end else if (bit_cnt_reg == 3'h7) begin
      rx_byte_reg <= {rx_sh_reg, mosi};
      rx_idx_reg <= byte_idx_reg;
      rx_tgl_reg <= ~rx_tgl_reg;
    end
  end

  // ans_reg settles 10 to 15 ns (third clk edge) after the last rising edge of a byte,
  // well inside the half sck period before it is sampled here
  always_ff @(negedge sck) begin
    if (off_s_reg[1]) begin
      miso <= 1'b0;
      tx_sh_reg <= 8'h00;
    end else if (bit_cnt_reg == 3'h0) begin
      miso <= ans_reg[7]; // see RQ24
      tx_sh_reg <= {ans_reg[6:0], 1'b0};
    end else begin
      miso <= tx_sh_reg[7];
      tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
    end
  end

  // Serial side, clk domain
  logic [2:0] tgl_s_reg;
  logic rx_evt;
  logic [7:0] b0_reg, b1_reg, ser_rd;
  logic [15:0] s_addr;

  always_ff @(posedge clk) begin
    tgl_s_reg <= {tgl_s_reg[1:0], rx_tgl_reg};
  end
  assign rx_evt = ser_act_reg && (tgl_s_reg[2] != tgl_s_reg[1]);
  assign s_addr = {b1_reg, rx_byte_reg};

  always_ff @(posedge clk) begin
    if (!rst_b || !ser_act_reg) begin
      ser_act_reg <= ~pin_s2.rst_pin_n & ~par_mode_reg; // see RQ23
      b0_reg <= 8'h00;
      b1_reg <= 8'h00;
      ans_reg <= 8'h00;
      prog_en_reg <= 1'b0;
    end else begin
      ser_act_reg <= ~pin_s2.rst_pin_n & ~par_mode_reg; // see RQ23
      if (rx_evt) begin
        ans_reg <= ser_rd; // see RQ25
        if (rx_idx_reg == 2'h0) begin
          b0_reg <= rx_byte_reg;
        end
        if (rx_idx_reg == 2'h1) begin
          b1_reg <= rx_byte_reg;
        end
        if (rx_idx_reg == 2'h3 && b0_reg == `NVMPI_OPC_AC &&
            b1_reg == `NVMPI_SUB_ENABLE) begin
          prog_en_reg <= 1'b1;
        end
      end
    end
  end

  // Answer for the next byte; default is an echo of the byte just in
  always_comb begin
    ser_rd = rx_byte_reg; // see RQ25
    if (rx_idx_reg == 2'h2 && prog_en_reg) begin
      case (b0_reg)
        `NVMPI_OPC_RD_HI: ser_rd = flash_hi[s_addr[FLASH_AW-1:0]]; // see RQ3
        `NVMPI_OPC_RD_LO: ser_rd = flash_lo[s_addr[FLASH_AW-1:0]]; // see RQ3
        `NVMPI_OPC_RD_EE: ser_rd = ee_mem[s_addr[EE_AW-1:0]]; // see RQ22
        `NVMPI_OPC_RD_LOCK: // see RQ6
          ser_rd = (b1_reg == `NVMPI_SUB_HI_SEL) ? fuse_hi_reg : lock_reg;
        `NVMPI_OPC_RD_FUSE: // see RQ6
          ser_rd = (b1_reg == `NVMPI_SUB_HI_SEL) ? fuse_ext_reg : fuse_lo_reg;
        `NVMPI_OPC_RD_SIG: ser_rd = sig_byte(rx_byte_reg[1:0]); // see RQ6
        `NVMPI_OPC_RD_CAL: ser_rd = CAL_BYTE; // see RQ6
        `NVMPI_OPC_POLL: ser_rd = {7'h00, busy}; // see RQ8
        default: ser_rd = rx_byte_reg;
      endcase
    end
  end

  always_comb begin
    ser_req.op = nvmpi_pkg::NVMPI_OP_NONE;
    ser_req.addr = {b1_reg, ans_reg};
    ser_req.data = rx_byte_reg;
    if (rx_evt && rx_idx_reg == 2'h3 && prog_en_reg) begin
      case (b0_reg)
        `NVMPI_OPC_LD_LO: ser_req.op = nvmpi_pkg::NVMPI_OP_FLASH_LD_LO; // see RQ1
        `NVMPI_OPC_LD_HI: ser_req.op = nvmpi_pkg::NVMPI_OP_FLASH_LD_HI;
        `NVMPI_OPC_EE_LD: ser_req.op = nvmpi_pkg::NVMPI_OP_EE_LD; // see RQ2
        `NVMPI_OPC_WR_PAGE: ser_req.op = nvmpi_pkg::NVMPI_OP_FLASH_WR; // see RQ4
        `NVMPI_OPC_WR_EE: ser_req.op = nvmpi_pkg::NVMPI_OP_EE_WR_BYTE; // see RQ22
        `NVMPI_OPC_WR_EE_PG: ser_req.op = nvmpi_pkg::NVMPI_OP_EE_WR_PAGE; // see RQ5
        `NVMPI_OPC_AC: begin
          case (b1_reg) // see RQ7
            `NVMPI_SUB_ERASE: ser_req.op = nvmpi_pkg::NVMPI_OP_ERASE;
            `NVMPI_SUB_LOCK: ser_req.op = nvmpi_pkg::NVMPI_OP_LOCK;
            `NVMPI_SUB_FUSE_LO: ser_req.op = nvmpi_pkg::NVMPI_OP_FUSE_LO;
            `NVMPI_SUB_FUSE_HI: ser_req.op = nvmpi_pkg::NVMPI_OP_FUSE_HI;
            `NVMPI_SUB_FUSE_EXT: ser_req.op = nvmpi_pkg::NVMPI_OP_FUSE_EXT;
            default: ser_req.op = nvmpi_pkg::NVMPI_OP_NONE;
          endcase
        end
        default: ser_req.op = nvmpi_pkg::NVMPI_OP_NONE;
      endcase
    end
  end

  // Parallel path
  logic [7:0] cmd_reg, addr_lo_reg, addr_hi_reg, pdata_reg, par_rd;
  logic xtal_rise, latch_rise, wr_fall;
  logic [1:0] act;

  assign xtal_rise = par_mode_reg && pin_s2.xtal && !pin_s3.xtal;
  assign latch_rise = par_mode_reg && pin_s2.bsel && !pin_s3.bsel;
  assign wr_fall = par_mode_reg && !pin_s2.wr_n && pin_s3.wr_n;
  assign act = {pin_s2.act_hi, pin_s2.act_lo};

  always_ff @(posedge clk) begin
    if (!rst_b || !pin_s2.hv) begin
      par_mode_reg <= 1'b0;
    end else if (pin_s2.hv && !pin_s3.hv && !pin_s2.rst_pin_n &&
                 {pin_s2.bsel, pin_s2.act_hi, pin_s2.act_lo,
                  pin_s2.wr_n} == 4'h0) begin
      par_mode_reg <= 1'b1; // see RQ16
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b || !par_mode_reg) begin
      cmd_reg <= 8'h00;
      addr_lo_reg <= 8'h00;
      addr_hi_reg <= 8'h00;
      pdata_reg <= 8'h00;
    end else if (xtal_rise) begin // see RQ17
      case (act) // see RQ18
        `NVMPI_ACT_ADDR: begin
          if (pin_s2.bsel) begin
            addr_hi_reg <= din_s2;
          end else begin
            addr_lo_reg <= din_s2;
          end
        end
        `NVMPI_ACT_DATA: pdata_reg <= din_s2;
        `NVMPI_ACT_CMD: cmd_reg <= din_s2;
        default: cmd_reg <= cmd_reg;
      endcase
    end
  end

  always_comb begin
    par_req.op = nvmpi_pkg::NVMPI_OP_NONE;
    par_req.addr = {addr_hi_reg, addr_lo_reg};
    par_req.data = pdata_reg;
    if (xtal_rise && act == `NVMPI_ACT_DATA &&
        cmd_reg == `NVMPI_CMD_WR_FLASH) begin
      par_req.data = din_s2; // see RQ15
      par_req.op = pin_s2.bsel ? nvmpi_pkg::NVMPI_OP_FLASH_LD_HI
                              : nvmpi_pkg::NVMPI_OP_FLASH_LD_LO;
    end else if (latch_rise && cmd_reg == `NVMPI_CMD_WR_EE) begin
      par_req.op = nvmpi_pkg::NVMPI_OP_EE_LD; // see RQ15
    end else if (wr_fall) begin
      case (cmd_reg) // see RQ19
        `NVMPI_CMD_ERASE: par_req.op = nvmpi_pkg::NVMPI_OP_ERASE; // see RQ20
        `NVMPI_CMD_WR_FUSE: begin
          if (pin_s2.bsel) begin // see RQ15
            par_req.op = nvmpi_pkg::NVMPI_OP_FUSE_HI;
          end else if (pin_s2.act_hi) begin
            par_req.op = nvmpi_pkg::NVMPI_OP_FUSE_EXT;
          end else begin
            par_req.op = nvmpi_pkg::NVMPI_OP_FUSE_LO;
          end
        end
        `NVMPI_CMD_WR_LOCK: par_req.op = nvmpi_pkg::NVMPI_OP_LOCK;
        `NVMPI_CMD_WR_FLASH: par_req.op = nvmpi_pkg::NVMPI_OP_FLASH_WR;
        `NVMPI_CMD_WR_EE: par_req.op = nvmpi_pkg::NVMPI_OP_EE_WR_PAGE;
        default: par_req.op = nvmpi_pkg::NVMPI_OP_NONE;
      endcase
    end
  end

  always_comb begin
    case (cmd_reg) // see RQ21
      `NVMPI_CMD_RD_SIG:
        par_rd = pin_s2.bsel ? CAL_BYTE : sig_byte(addr_lo_reg[1:0]);
      `NVMPI_CMD_RD_FUSE: begin
        case ({pin_s2.act_hi, pin_s2.bsel})
          2'h0: par_rd = fuse_lo_reg;
          2'h1: par_rd = lock_reg;
          2'h2: par_rd = fuse_ext_reg;
          default: par_rd = fuse_hi_reg;
        endcase
      end
      `NVMPI_CMD_RD_FLASH: par_rd = pin_s2.bsel ?
        flash_hi[par_req.addr[FLASH_AW-1:0]] :
        flash_lo[par_req.addr[FLASH_AW-1:0]];
      `NVMPI_CMD_RD_EE: par_rd = ee_mem[par_req.addr[EE_AW-1:0]];
      default: par_rd = `NVMPI_ERASED;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      data_out <= 8'h00;
      data_oe_n <= 1'b1;
    end else begin
      data_out <= par_rd;
      data_oe_n <= ~(par_mode_reg & ~pin_s2.oe_n); // see RQ13
    end
  end

  // Modes exclude each other, so a plain merge is enough
  assign req = (ser_req.op != nvmpi_pkg::NVMPI_OP_NONE) ? ser_req : par_req;

  // Busy timer; a programming request while busy is dropped
  assign busy = (state_reg == nvmpi_pkg::NVMPI_BUSY);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg <= nvmpi_pkg::NVMPI_IDLE;
      busy_cnt_reg <= 24'h000000;
    end else begin
      case (state_reg)
        nvmpi_pkg::NVMPI_IDLE: begin
          if (is_prog(req.op)) begin
            state_reg <= nvmpi_pkg::NVMPI_BUSY;
            busy_cnt_reg <= op_cycles(req.op) - 24'h000001;
          end
        end
        nvmpi_pkg::NVMPI_BUSY: begin
          if (busy_cnt_reg == 24'h000000) begin
            state_reg <= nvmpi_pkg::NVMPI_IDLE;
          end else begin
            busy_cnt_reg <= busy_cnt_reg - 24'h000001;
          end
        end
        default: state_reg <= nvmpi_pkg::NVMPI_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ready_busy <= 1'b0;
      prog_active <= 1'b0;
    end else begin
      ready_busy <= ~busy & ~is_prog(req.op); // see RQ14
      prog_active <= par_mode_reg | prog_en_reg;
    end
  end

  // Fuse and lock cells: erased value is all ones, a zero is programmed
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fuse_lo_reg <= `NVMPI_ERASED; // see RQ11
      fuse_hi_reg <= `NVMPI_ERASED;
      fuse_ext_reg <= `NVMPI_ERASED;
      lock_reg <= `NVMPI_ERASED;
    end else if (!busy) begin
      case (req.op) // see RQ7
        nvmpi_pkg::NVMPI_OP_FUSE_LO: fuse_lo_reg <= req.data;
        nvmpi_pkg::NVMPI_OP_FUSE_HI: fuse_hi_reg <= req.data;
        nvmpi_pkg::NVMPI_OP_FUSE_EXT: fuse_ext_reg <= req.data;
        nvmpi_pkg::NVMPI_OP_LOCK: lock_reg <= req.data;
        nvmpi_pkg::NVMPI_OP_ERASE: lock_reg <= `NVMPI_ERASED;
        default: lock_reg <= lock_reg;
      endcase
    end
  end

  // Array contents are not reset; they model nonvolatile cells
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ee_mask_reg <= '0;
    end else if (req.op == nvmpi_pkg::NVMPI_OP_FLASH_LD_LO) begin
      fbuf_lo[req.addr[FLASH_PW-1:0]] <= req.data; // see RQ10
    end else if (req.op == nvmpi_pkg::NVMPI_OP_FLASH_LD_HI) begin
      fbuf_hi[req.addr[FLASH_PW-1:0]] <= req.data; // see RQ10
    end else if (req.op == nvmpi_pkg::NVMPI_OP_EE_LD) begin
      ee_buf[req.addr[EE_PW-1:0]] <= req.data; // see RQ2
      ee_mask_reg[req.addr[EE_PW-1:0]] <= 1'b1;
    end else if (!busy) begin
      case (req.op)
        nvmpi_pkg::NVMPI_OP_FLASH_WR: begin // see RQ4
          for (int i = 0; i < FLASH_PAGE; i++) begin
            flash_lo[{req.addr[FLASH_AW-1:FLASH_PW], i[FLASH_PW-1:0]}] <=
              fbuf_lo[i];
            flash_hi[{req.addr[FLASH_AW-1:FLASH_PW], i[FLASH_PW-1:0]}] <=
              fbuf_hi[i];
            fbuf_lo[i] <= `NVMPI_ERASED;
            fbuf_hi[i] <= `NVMPI_ERASED;
          end
        end
        nvmpi_pkg::NVMPI_OP_EE_WR_PAGE: begin
          for (int i = 0; i < EE_PAGE; i++) begin
            if (ee_mask_reg[i]) begin // see RQ5
              ee_mem[{req.addr[EE_AW-1:EE_PW], i[EE_PW-1:0]}] <= ee_buf[i];
            end
          end
          ee_mask_reg <= '0;
        end
        nvmpi_pkg::NVMPI_OP_EE_WR_BYTE:
          ee_mem[req.addr[EE_AW-1:0]] <= req.data; // see RQ22
        nvmpi_pkg::NVMPI_OP_ERASE: begin
          for (int i = 0; i < FLASH_WORDS; i++) begin
            flash_lo[i] <= `NVMPI_ERASED;
            flash_hi[i] <= `NVMPI_ERASED;
          end
          for (int i = 0; i < EE_BYTES; i++) begin
            ee_mem[i] <= `NVMPI_ERASED;
          end
        end
        default: ee_mask_reg <= ee_mask_reg;
      endcase
    end
  end
endmodule

// file: tb/nvmpi_checker.sv
// Purpose: Port assertions for the programming front end
// Assumes: Bound to nvmpi_core, single system clock domain
// Notes: Busy bound follows the longest shortened operation
`timescale 1ns/1ps
module nvmpi_checker #(
  parameter int T_ERASE_CYC = 20
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic reset_pin_n,
  input wire logic out_en_n,
  input wire logic [7:0] data_out,
  input wire logic data_oe_n,
  input wire logic ready_busy,
  input wire logic prog_active
);
  logic [15:0] busy_cnt;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  sequence busy_run;
    !ready_busy [*8];
  endsequence
  // Counter instead of long repetition keeps tools fast
  always_ff @(posedge clk) begin
    if (!rst_b || ready_busy)
      busy_cnt <= '0;
    else
      busy_cnt <= busy_cnt + 16'h0001;
  end
  chk_reset_quiet:
    assert property ($rose(rst_b) |-> data_oe_n && !prog_active
      && data_out == 8'h00) else $error("Outputs not quiet at reset");
  chk_ready_after_rst:
    assert property ($rose(rst_b) |=> ready_busy)
      else $error("Not ready after reset");
  chk_oe_needs_mode:
    assert property (!data_oe_n |-> prog_active)
      else $error("Bus driven outside programming");
  chk_oe_released:
    assert property (out_en_n [*6] |-> data_oe_n)
      else $error("Bus driven with enable high");
  chk_oe_follows:
    assert property ($fell(data_oe_n) |-> !$past(out_en_n, 2))
      else $error("Bus driven without enable");
  chk_entry_pin:
    assert property ($rose(prog_active) |-> !reset_pin_n
      && !$past(reset_pin_n, 3)) else $error("Entry without reset pin");
  chk_busy_hold:
    assert property ($fell(ready_busy) |-> busy_run)
      else $error("Busy too short");
  chk_busy_bounded:
    assert property (busy_cnt <= T_ERASE_CYC + 16)
      else $error("Busy too long");
endmodule

bind nvmpi_core nvmpi_checker #(.T_ERASE_CYC(T_ERASE_CYC)) i_nvmpi_checker (.*);

// file: tb/nvmpi_spi_host.sv
// Purpose: Serial programmer model, one 4-byte frame per call
// Assumes: 125 ns link period, clock idle low between frames
// Notes: Data line inverted after a frame, never left stale
`timescale 1ns/1ps
module nvmpi_spi_host (
  output logic sck,
  output logic mosi,
  input wire logic miso
);
  initial begin
    sck = 1'b0;
    mosi = 1'b0;
  end
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    #1.3; // Keeps link edges off the system clock edges
    for (int i = 31; i >= 0; i--) begin
      mosi = tx[i];
      #62.5 sck = 1'b1;
      rx[i] = miso;
      #62.5 sck = 1'b0;
    end
    mosi = ~mosi;
    #62.5;
  endtask
  // Link side leaves its reset only after two idle clocks
  task automatic pulse(input int n);
    for (int i = 0; i < n; i++) begin
      #62.5 sck = 1'b1;
      #62.5 sck = 1'b0;
    end
  endtask
endmodule

// file: tb/test_nvm_programming_interface.sv
// Purpose: Self-checking bench for the programming front end
// Assumes: Serial host model drives the link pins
// Notes: Op times shortened so that polling still sees busy
`timescale 1ns/1ps
module test_nvm_programming_interface;
  localparam int T_OP = 3000;
  // Identity values are arbitrary
  localparam logic [7:0] SIG [3] = '{8'h12, 8'h34, 8'h56};
  localparam logic [7:0] CAL = 8'h9C;
  localparam logic [15:0] RDC [4] = '{16'h5800, 16'h5000, 16'h5808,
    16'h5008};
  localparam logic [7:0] WRS [4] = '{8'hE0, 8'hA0, 8'hA8, 8'hA4};
  localparam logic [7:0] PC [4] = '{8'h40, 8'h40, 8'h40, 8'h20};
  localparam logic [1:0] WS [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
  localparam logic [1:0] RS [4] = '{2'h0, 2'h3, 2'h2, 2'h1};
  logic clk = 0, rst_b = 0, sck, mosi, miso, reset_pin_n = 1;
  logic hv_prog = 0, load_strobe_clock_pin = 0, action_select_lo = 0;
  logic action_select_hi = 0, byte_select_first = 0, write_n = 0;
  logic out_en_n = 1, data_oe_n, ready_busy, prog_active;
  logic [7:0] data_in = 8'h00, data_out, d, f [4];
  logic [31:0] r;
  int n_errors = 0, n_tests = 0;
  nvmpi_core #(.T_FLASH_CYC(T_OP), .T_EEPROM_CYC(T_OP), .T_ERASE_CYC(T_OP),
    .T_FUSE_CYC(T_OP), .SIG_BYTE0(SIG[0]), .SIG_BYTE1(SIG[1]),
    .SIG_BYTE2(SIG[2]), .CAL_BYTE(CAL)) i_nvmpi_core (.*);
  nvmpi_spi_host i_nvmpi_spi_host (.*);
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input logic [31:0] t);
    i_nvmpi_spi_host.xfer(t, r);
  endtask
  task automatic wait_ready();
    for (int k = 0; k < 40; k++) begin
      cmd(32'hF0000000);
      if (r[0] === 1'b0)
        return;
    end
    check(r[7:0], 8'h00);
    complete_run();
  endtask
  task automatic strobe(input logic [1:0] act, input logic b1,
    input logic [7:0] v);
    {action_select_hi, action_select_lo} = act;
    byte_select_first = b1;
    data_in = v;
    repeat (8) @(negedge clk);
    load_strobe_clock_pin = 1;
    repeat (60) @(negedge clk);
    load_strobe_clock_pin = 0;
    repeat (8) @(negedge clk);
  endtask
  task automatic par_rd(input logic [1:0] sel, input logic [7:0] exp);
    {action_select_hi, byte_select_first} = sel;
    out_en_n = 0;
    repeat (12) @(negedge clk);
    check(data_out, exp);
    check({7'h00, data_oe_n}, 8'h00);
    out_en_n = 1;
    repeat (12) @(negedge clk);
  endtask
  initial begin
    d = $urandom(45965);
    repeat (6) @(negedge clk);
    rst_b = 1;
    cmd(32'h0); // Clears the link side while the pin is high
    @(negedge clk);
    reset_pin_n = 0;
    repeat (200) @(negedge clk);
    i_nvmpi_spi_host.pulse(2);
    cmd(32'hAC530000);
    check(r[15:8], 8'h53);
    for (int i = 0; i < 4; i++) begin
      f[i] = $urandom;
      cmd({RDC[i], 16'h0000});
      check(r[7:0], 8'hFF);
      cmd({8'hAC, WRS[i], 8'h00, f[i]});
      cmd(32'hF0000000);
      check(r[7:0], 8'h01);
      wait_ready();
      cmd({RDC[i], 16'h0000});
      check(r[7:0], f[i]);
    end
    for (int i = 0; i < 3; i++) begin
      cmd({16'h3000, 8'(i), 8'h00});
      check(r[7:0], SIG[i]);
    end
    cmd(32'h38000000);
    check(r[7:0], CAL);
    $display("Fuse, lock and identity test done");
    // Word 3 then word 1 of page 2, low byte first each
    for (int i = 0; i < 4; i++) begin
      f[i] = $urandom;
      cmd({i[0] ? 8'h48 : 8'h40, 8'h00, i[1] ? 8'h41 : 8'h43, f[i]});
    end
    cmd(32'h4C004000);
    wait_ready();
    for (int i = 0; i < 4; i++) begin
      cmd({i[0] ? 8'h28 : 8'h20, 8'h00, i[1] ? 8'h41 : 8'h43, 8'h00});
      check(r[7:0], f[i]);
    end
    $display("Serial flash test done");
    d = $urandom;
    cmd({24'hC00024, d});
    wait_ready();
    cmd({24'hC10001, f[0]});
    cmd(32'hC2002400);
    wait_ready();
    cmd(32'hA0002400);
    check(r[7:0], d);
    cmd(32'hA0002500);
    check(r[7:0], f[0]);
    $display("Serial EEPROM test done");
    @(negedge clk);
    rst_b = 0;
    repeat (6) @(negedge clk);
    rst_b = 1;
    repeat (8) @(negedge clk);
    hv_prog = 1;
    repeat (20) @(negedge clk);
    check({7'h00, prog_active}, 8'h01);
    write_n = 1;
    strobe(2'b10, 1'b0, 8'h04);
    par_rd(2'b00, 8'hFF);
    for (int i = 0; i < 4; i++) begin
      d = $urandom;
      strobe(2'b10, 1'b0, PC[i]);
      strobe(2'b01, 1'b0, d);
      {action_select_hi, byte_select_first} = WS[i];
      write_n = 0;
      repeat (60) @(negedge clk);
      write_n = 1;
      repeat (4) @(negedge clk);
      check({7'h00, ready_busy}, 8'h00);
      for (int k = 0; k < 5000 && ready_busy !== 1'b1; k++)
        @(negedge clk);
      check({7'h00, ready_busy}, 8'h01);
      if (ready_busy !== 1'b1)
        complete_run();
      strobe(2'b10, 1'b0, 8'h04);
      par_rd(RS[i], d);
    end
    $display("Parallel fuse and lock test done");
    strobe(2'b10, 1'b0, 8'h02);
    strobe(2'b00, 1'b1, 8'h00);
    strobe(2'b00, 1'b0, 8'h43);
    par_rd(2'b00, f[0]);
    par_rd(2'b01, f[1]);
    strobe(2'b10, 1'b0, 8'h08);
    par_rd(2'b01, CAL);
    strobe(2'b10, 1'b0, 8'h03);
    strobe(2'b00, 1'b0, 8'h25);
    par_rd(2'b00, f[0]);
    $display("Parallel flash read test done");
    complete_run();
  end
endmodule
